// ===== hdl/local_data_error_checker.sv
// disk sector check code, local ram parity and tape exception handling
// assumes one board clock; all inputs synchronous to it
`include "local_data_error_checker_map.svh"
`default_nettype none
module local_data_error_checker #(
  parameter int unsigned SECTOR_LEN = 512
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_sector_start,
  input  wire logic        i_sector_write,
  input  wire logic        i_disk_byte_valid,
  input  wire logic [7:0]  i_disk_byte_path,
  input  wire logic        i_check_ready,
  output logic             o_check_valid,
  output logic [7:0]       o_serial_word_bus,
  output logic             o_sector_done,
  output logic             o_check_error,
  output logic [31:0]      o_check_code,
  input  wire logic        i_clear_errors,
  input  wire logic        i_ram_write,
  input  wire logic [15:0] i_ram_write_data,
  output logic [1:0]       o_ram_parity_write,
  input  wire logic        i_ram_read,
  input  wire logic [15:0] i_local_ram_data_bus,
  input  wire logic [1:0]  i_ram_parity_read,
  output logic             o_parity_error,
  output logic             o_nmi,
  input  wire logic        i_tape_exception,
  output logic             o_tape_status_req
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    local_data_error_checker_pkg::phase_type phase;
    logic        write;
    logic [9:0]  count;
    logic [2:0]  chk_idx;
    logic [31:0] code;
    logic [31:0] out_code;
    logic        check_error;
    logic        parity_error;
    logic        done;
    logic        tape_seen;
    logic        tape_req;
  } state_type;

  state_type cur;
  state_type next_cur;

  // one byte through the msb-first crc, zero seed so good reads give 0
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  d);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[31] ^ d[i]) begin
        r = {r[30:0], 1'b0} ^ `CHK_POLY;
      end else begin
        r = {r[30:0], 1'b0};
      end
    end
    return r;
  endfunction

  function automatic logic [1:0] byte_par(input logic [15:0] w);
    return {^w[15:8], ^w[7:0]};
  endfunction

  logic byte_take;
  logic last_byte;
  logic chk_take;
  logic par_mismatch;
  logic chk_fail;

  assign byte_take = (cur.phase == local_data_error_checker_pkg::st_data)
                     && i_disk_byte_valid;
  assign last_byte = byte_take
                     && (cur.count == 10'(SECTOR_LEN - 1));
  assign chk_take  = (cur.phase == local_data_error_checker_pkg::st_check)
                     && (cur.write ? i_check_ready : i_disk_byte_valid);
  assign par_mismatch = i_ram_read
    && (byte_par(i_local_ram_data_bus) != i_ram_parity_read);
  // verdict of a finished read: any nonzero leftover code is a bad sector
  assign chk_fail = (cur.phase == local_data_error_checker_pkg::st_done)
                    && !cur.write && (cur.code != 32'h00000000);

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    next_cur.tape_req = 1'b0;
    case (cur.phase)
      local_data_error_checker_pkg::st_idle: begin
      end
      local_data_error_checker_pkg::st_data: begin
        if (byte_take) begin
          next_cur.code = crc_byte(cur.code, i_disk_byte_path);
          next_cur.count = cur.count + 10'h001;
        end
        if (last_byte) begin
          next_cur.phase = local_data_error_checker_pkg::st_check;
          next_cur.chk_idx = 3'h0;
          next_cur.out_code = crc_byte(cur.code, i_disk_byte_path);
        end
      end
      local_data_error_checker_pkg::st_check: begin
        if (chk_take) begin
          next_cur.chk_idx = cur.chk_idx + 3'h1;
          if (cur.write) begin
            next_cur.out_code = {cur.out_code[23:0], 8'h00};
          end else begin
            next_cur.code = crc_byte(cur.code, i_disk_byte_path);
          end
          if (cur.chk_idx == `CHK_BYTES - 3'h1) begin
            next_cur.phase = local_data_error_checker_pkg::st_done;
          end
        end
      end
      local_data_error_checker_pkg::st_done: begin
        next_cur.done = 1'b1;
        next_cur.phase = local_data_error_checker_pkg::st_idle;
        // code kept in cur.code for software reconstruction; the flag
        // itself is set below so that it can beat a coincident clear
      end
      default: next_cur.phase = local_data_error_checker_pkg::st_idle;
    endcase
    // a new sector clears old check error, not parity error, and restarts the code
    if (i_sector_start) begin
      next_cur.phase = local_data_error_checker_pkg::st_data;
      next_cur.write = i_sector_write;
      next_cur.count = 10'h000;
      next_cur.code = `CHK_SEED;
      next_cur.check_error = 1'b0;
    end
    if (i_clear_errors) begin
      next_cur.check_error = 1'b0;
      next_cur.parity_error = 1'b0;
    end
    // a failing read beats a clear in the same cycle; only a new sector
    // start wins over it, since that begins a fresh verdict
    if (chk_fail && !i_sector_start) begin
      next_cur.check_error = 1'b1;
    end
    // set beats clear so a coincident mismatch is not lost
    if (par_mismatch) begin
      next_cur.parity_error = 1'b1;
    end
    // one request pulse per rising exception
    next_cur.tape_seen = i_tape_exception;
    if (i_tape_exception && !cur.tape_seen) begin
      next_cur.tape_req = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cur <= '0;
    end else if (i_ce) begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign o_check_valid = (cur.phase == local_data_error_checker_pkg::st_check)
                         && cur.write;
  assign o_serial_word_bus = cur.out_code[31:24];
  assign o_sector_done = cur.done;
  assign o_check_error = cur.check_error;
  assign o_check_code = cur.code;
  // parity bits for the two extra one-bit memories; combinational with data
  assign o_ram_parity_write = i_ram_write ? byte_par(i_ram_write_data)
                                          : 2'b00;
  assign o_parity_error = cur.parity_error;
  assign o_nmi = cur.parity_error;
  assign o_tape_status_req = cur.tape_req;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  parity_flag_set_a: assert property (
    i_ce && par_mismatch |=> o_parity_error)
    else $error("parity mismatch not flagged");
  nmi_source_a: assert property (
    $rose(o_nmi) |-> $past(i_ce && par_mismatch))
    else $error("nmi raised without a parity mismatch");
  parity_gen_a: assert property (
    i_ram_write |-> o_ram_parity_write
      == {^i_ram_write_data[15:8], ^i_ram_write_data[7:0]})
    else $error("bad generated parity");
  tape_req_a: assert property (
    i_ce && i_tape_exception && !cur.tape_seen |=> o_tape_status_req)
    else $error("tape status not requested");
  start_clears_a: assert property (
    i_ce && i_sector_start |=> !o_check_error)
    else $error("check error survives sector start");
  good_read_a: assert property (
    i_ce && !i_sector_start && !i_clear_errors && !cur.write
    && cur.phase == local_data_error_checker_pkg::st_done
    && cur.code == 32'h0 && !cur.check_error |=> !o_check_error)
    else $error("good sector flagged");
  bad_read_a: assert property (
    i_ce && !i_sector_start && !cur.write
    && cur.phase == local_data_error_checker_pkg::st_done
    && cur.code != 32'h0 |=> o_check_error && $stable(o_check_code))
    else $error("bad sector not flagged");
  sector_len_a: assert property (
    i_ce && last_byte && !i_sector_start
    |=> cur.phase == local_data_error_checker_pkg::st_check)
    else $error("sector framing wrong");
  four_bytes_a: assert property (
    cur.phase == local_data_error_checker_pkg::st_check
    |-> cur.chk_idx < `CHK_BYTES)
    else $error("too many check bytes");

  write_sector_c: cover property (o_check_valid && i_check_ready);
  set_beats_clear_c: cover property (i_ce && chk_fail && i_clear_errors);
  read_fail_c: cover property ($rose(o_check_error));
  parity_c: cover property ($rose(o_nmi));
  tape_c: cover property (o_tape_status_req);

endmodule
`default_nettype wire

// ===== include/local_data_error_checker_map.svh
// constants for the local data error checker
// assumes inclusion once per compile unit; guarded anyway
`ifndef LOCAL_DATA_ERROR_CHECKER_MAP_SVH
`define LOCAL_DATA_ERROR_CHECKER_MAP_SVH

// ----------------------------------------------------------------------
// check code, sector length and tape request
// ----------------------------------------------------------------------
`define CHK_POLY        32'h04c11db7
`define CHK_SEED        32'h00000000
`define CHK_BYTES       3'h4
`define SECTOR_BYTES    10'h200
`define TAPE_REQ_CYCLES 1

`endif

// ===== include/local_data_error_checker_pkg.sv
// types for the local data error checker
// assumes the map header is compiled alongside
`default_nettype none
package local_data_error_checker_pkg;
  // gray coded along idle -> data -> check -> done
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_data  = 2'b01,
    st_check = 2'b11,
    st_done  = 2'b10
  } phase_type;
endpackage
`default_nettype wire

// ===== dv/disk_serializer_model.sv
// serializer side model: takes check bytes off the word bus
// assumes bytes are offered while o_check_valid is high
`default_nettype none
module disk_serializer_model (
  input  wire logic        i_clk,
  input  wire logic        i_slow,
  input  wire logic        i_check_valid,
  input  wire logic [7:0]  i_serial_word_bus,
  output logic             o_check_ready,
  output logic [31:0]      o_captured
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_check_ready = 1'b0;
  initial o_captured = 32'h0;
  // a slow disk only takes every other cycle, stressing the hold
  always @(posedge i_clk) begin
    if (i_check_valid && o_check_ready) begin
      o_captured <= {o_captured[23:0], i_serial_word_bus};
    end
    o_check_ready <= #1 i_slow ? ~o_check_ready : 1'b1;
  end
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// bench for the checker: disk sectors, ram parity, tape exception
// assumes the serializer model records the four check bytes
`include "local_data_error_checker_map.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned N = `SECTOR_BYTES; // full hardware sector
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, slow = 1'b0;
  logic i_sector_start = 1'b0, i_sector_write = 1'b0;
  logic i_disk_byte_valid = 1'b0, i_clear_errors = 1'b0;
  logic i_ram_write = 1'b0, i_ram_read = 1'b0, i_tape_exception = 1'b0;
  logic [7:0] i_disk_byte_path = 8'h0, o_serial_word_bus;
  logic [15:0] i_ram_write_data = 16'h0, i_local_ram_data_bus = 16'h0;
  logic [1:0] i_ram_parity_read = 2'h0, o_ram_parity_write;
  logic i_check_ready, o_check_valid, o_sector_done, o_check_error;
  logic o_parity_error, o_nmi, o_tape_status_req;
  logic [31:0] o_check_code, cap;
  logic [7:0] dat [N];
  int fails = 0, compares = 0;
  local_data_error_checker #(.SECTOR_LEN(N)) dut (.i_clk, .i_rst_n,
    .i_ce, .i_sector_start, .i_sector_write, .i_disk_byte_valid,
    .i_disk_byte_path, .i_check_ready, .o_check_valid, .o_serial_word_bus,
    .o_sector_done, .o_check_error, .o_check_code, .i_clear_errors,
    .i_ram_write, .i_ram_write_data, .o_ram_parity_write, .i_ram_read,
    .i_local_ram_data_bus, .i_ram_parity_read, .o_parity_error, .o_nmi,
    .i_tape_exception, .o_tape_status_req);
  disk_serializer_model partner (.i_clk, .i_slow(slow),
    .i_check_valid(o_check_valid), .i_serial_word_bus(o_serial_word_bus),
    .o_check_ready(i_check_ready), .o_captured(cap));
  initial forever #5 i_clk = ~i_clk;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic step();
    @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      fails++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // msb-first code, seed zero, so data plus code leaves zero
  function automatic logic [31:0] crc(input logic [31:0] c,
                                      input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ b[i]) ? `CHK_POLY : 32'h0);
    return c;
  endfunction
  // a read also feeds back the four recorded bytes, flip spoils byte 0
  task automatic run_sector(input logic wr, input logic [7:0] flip);
    int n;
    i_sector_start = 1'b1;
    i_sector_write = wr;
    step();
    i_sector_start = 1'b0;
    chk(o_check_error === 1'b0, "start kept error");
    for (int k = 0; k < N + (wr ? 0 : 4); k++) begin
      i_disk_byte_valid = 1'b1;
      i_disk_byte_path = k < N ? dat[k] : 8'(cap >> (8 * (N + 3 - k)));
      if (k == 0) i_disk_byte_path = i_disk_byte_path ^ flip;
      step();
    end
    i_disk_byte_valid = 1'b0;
    for (n = 0; o_sector_done !== 1'b1; n++) begin
      if (n > 60) begin
        chk(1'b0, "no sector end");
        test_done();
      end
      step();
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic write_sector();
    logic [31:0] e;
    e = 32'h0;
    for (int k = 0; k < N; k++) e = crc(e, dat[k]);
    for (int s = 1; s >= 0; s--) begin
      slow = s[0];
      run_sector(1'b1, 8'h0);
      chk(cap === e, "written check bytes");
    end
  endtask
  // without clr a clear is held all through: the failing verdict must win
  task automatic read_bad(input logic clr);
    logic [31:0] e;
    e = crc(32'h0, dat[0] ^ 8'h01);
    for (int k = 1; k < N; k++) e = crc(e, dat[k]);
    for (int k = 3; k >= 0; k--) e = crc(e, 8'(cap >> (8 * k)));
    i_clear_errors = ~clr;
    run_sector(1'b0, 8'h01);
    i_clear_errors = 1'b0;
    chk(o_check_error === 1'b1, "bad sector passed");
    repeat (3) step();
    chk(o_check_error === 1'b1 && o_check_code === e, "code lost");
    if (clr) begin
      i_clear_errors = 1'b1;
      step();
      i_clear_errors = 1'b0;
      chk(o_check_error === 1'b0, "clear ignored");
    end
  endtask
  task automatic read_good();
    run_sector(1'b0, 8'h0);
    chk(o_check_error === 1'b0 && o_check_code === 32'h0, "good");
  endtask
  task automatic ram_parity(input logic [15:0] d);
    i_ram_write = 1'b1;
    i_ram_write_data = d;
    #1;
    chk(o_ram_parity_write === {^d[15:8], ^d[7:0]}, "parity gen");
    step();
    i_ram_write = 1'b0;
    i_ram_read = 1'b1;
    i_local_ram_data_bus = d;
    i_ram_parity_read = {^d[15:8], ^d[7:0]};
    step();
    chk(o_parity_error === 1'b0, "false parity error");
    // spoil one stored bit: high byte on odd data, low byte otherwise
    i_ram_parity_read = i_ram_parity_read ^ (d[0] ? 2'h2 : 2'h1);
    step();
    i_ram_read = 1'b0;
    repeat (2) step();
    chk(o_parity_error === 1'b1 && o_nmi === 1'b1, "parity miss");
    i_clear_errors = 1'b1;
    step();
    i_clear_errors = 1'b0;
    chk(o_parity_error === 1'b0 && o_nmi === 1'b0, "parity stuck");
  endtask
  task automatic tape_exception();
    int n;
    n = 0;
    i_ce = 1'b0; // frozen block must not see the edge yet
    i_tape_exception = 1'b1;
    repeat (3) begin
      step();
      n += int'(o_tape_status_req === 1'b1);
    end
    chk(n == 0, "request while disabled");
    i_ce = 1'b1;
    repeat (6) begin
      step();
      n += int'(o_tape_status_req === 1'b1);
    end
    i_tape_exception = 1'b0;
    step();
    chk(n == 1, "status request count");
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    for (int k = 0; k < N; k++) dat[k] = 8'(k * 29 + 5);
    repeat (8) step();
    i_rst_n = 1'b1;
    step();
    write_sector();
    read_bad(1'b1);
    read_bad(1'b0);
    read_good();
    ram_parity(16'ha5f1);
    ram_parity(16'h0180);
    tape_exception();
    test_done();
  end
endmodule
`default_nettype wire
